//--- inc/nvecc_pkg.sv
package nvecc_pkg;

  // ==========================================================================
  // Bus geometry.
  // ==========================================================================
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned IDX_W = 8;
  localparam int unsigned REG_W = 8;
  localparam int unsigned NUM_BANKS = 8;
  localparam int unsigned BANK_W = 3;

  // ==========================================================================
  // Register indices; the byte address is four times the index.
  // ==========================================================================
  localparam logic [IDX_W-1:0] IDX_NVM_CLEAR = 8'h5e;
  localparam logic [IDX_W-1:0] IDX_BANK_FLAGS = 8'h60;
  localparam logic [IDX_W-1:0] IDX_LOAD_STATUS = 8'h61;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 8'h62;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'h63;
  localparam logic [IDX_W-1:0] IDX_CFG_ID1 = 8'h64;
  localparam logic [IDX_W-1:0] IDX_CFG_ID2 = 8'h65;

  // ==========================================================================
  // Field positions.
  // ==========================================================================
  localparam int unsigned POS_NVM_FAULT_CLEAR = 4;
  localparam int unsigned POS_CONFIG_VALID = 1;
  localparam int unsigned POS_LOW_VOLTAGE = 0;
  localparam int unsigned POS_IRQ_UNCORR = 0;
  localparam int unsigned POS_IRQ_LOW_VOLTAGE = 1;
  localparam int unsigned POS_IRQ_LOAD_DONE = 2;
  localparam int unsigned IRQ_W = 3;

  // ==========================================================================
  // Reset values.
  // ==========================================================================
  localparam logic [REG_W-1:0] RST_BANK_FLAGS = 8'h00;
  localparam logic [REG_W-1:0] RST_LOAD_STATUS = 8'h00;
  localparam logic [IRQ_W-1:0] RST_IRQ_STATUS = 3'h0;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 3'h0;
  localparam logic [REG_W-1:0] RST_CFG_ID = 8'h00;

  // ==========================================================================
  // Carriers.
  // ==========================================================================
  typedef struct packed {
    logic valid;
    logic [BANK_W-1:0] bank;
  } nvecc_ecc_evt_s;

  typedef struct packed {
    logic valid;
    logic [REG_W-1:0] id1;
    logic [REG_W-1:0] id2;
  } nvecc_load_evt_s;

endpackage

//--- hw/nvecc_status.sv
`timescale 1ns/1ps

// Contract
// - Eight flags, bit n flags bank n uncorrectable.
// - Writing 1 to 0x5E bit 4 clears flags.
// - Config valid when either identifier is nonzero.
// - Bit 0 latches low memory supply voltage.
// - Same clear bit clears both status flags.
// - All flags start at zero after reset.
module nvecc_status (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [nvecc_pkg::ADDR_W-1:0] WB_ADR_I,
  input wire logic [nvecc_pkg::SEL_W-1:0] WB_SEL_I,
  input wire logic [nvecc_pkg::DATA_W-1:0] WB_DAT_I,
  output logic [nvecc_pkg::DATA_W-1:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire nvecc_pkg::nvecc_ecc_evt_s ECC_EVT,
  input wire nvecc_pkg::nvecc_load_evt_s LOAD_EVT,
  input wire logic NVM_VDD_LOW,
  output logic NVM_CLEAR,
  output logic IRQ
);

  // ==========================================================================
  // Helper functions.
  // ==========================================================================

  // Word index of a byte address; the two low address bits are ignored.
  function automatic logic [nvecc_pkg::IDX_W-1:0] word_index(
    input logic [nvecc_pkg::ADDR_W-1:0] adr
  );
    logic [nvecc_pkg::ADDR_W-1:0] shifted;
    shifted = adr >> 2;
    return shifted[nvecc_pkg::IDX_W-1:0];
  endfunction

  // True when the upper address bits are zero, so aliases do not decode.
  function automatic logic in_window(
    input logic [nvecc_pkg::ADDR_W-1:0] adr
  );
    logic [nvecc_pkg::ADDR_W-1:0] upper;
    upper = adr >> (nvecc_pkg::IDX_W + 2);
    return (upper == '0);
  endfunction

  // Sticky flag update: a set in the same cycle as a clear wins.
  function automatic logic [nvecc_pkg::REG_W-1:0] sticky(
    input logic [nvecc_pkg::REG_W-1:0] cur,
    input logic [nvecc_pkg::REG_W-1:0] set,
    input logic [nvecc_pkg::REG_W-1:0] clr
  );
    return (cur & ~clr) | set;
  endfunction

  // Widen one register byte to a bus word, upper bits zero.
  function automatic logic [nvecc_pkg::DATA_W-1:0] to_word(
    input logic [nvecc_pkg::REG_W-1:0] val
  );
    return {{(nvecc_pkg::DATA_W-nvecc_pkg::REG_W){1'b0}}, val};
  endfunction

  // ==========================================================================
  // Declarations.
  // ==========================================================================
  logic ack_reg;
  logic [nvecc_pkg::DATA_W-1:0] rdata_reg;
  logic [nvecc_pkg::DATA_W-1:0] rdata_next;
  logic req;
  logic wr_take;
  logic rd_take;
  logic lane0;
  logic [nvecc_pkg::IDX_W-1:0] idx;
  logic hit;
  logic [nvecc_pkg::REG_W-1:0] wbyte;

  logic clear_pulse;

  logic [nvecc_pkg::REG_W-1:0] bank_flags_reg;
  logic [nvecc_pkg::REG_W-1:0] bank_flags_next;
  logic [nvecc_pkg::REG_W-1:0] bank_set;

  logic config_valid_reg;
  logic config_valid_next;
  logic low_voltage_reg;
  logic low_voltage_next;
  logic [nvecc_pkg::REG_W-1:0] cfg_id1_reg;
  logic [nvecc_pkg::REG_W-1:0] cfg_id2_reg;
  logic load_ids_nonzero;

  logic vdd_meta_reg;
  logic vdd_s2_reg;
  logic vdd_s3_reg;
  logic vdd_low_reg;
  logic vdd_low_rise;

  logic [nvecc_pkg::IRQ_W-1:0] irq_status_reg;
  logic [nvecc_pkg::IRQ_W-1:0] irq_status_next;
  logic [nvecc_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [nvecc_pkg::IRQ_W-1:0] irq_set;
  logic [nvecc_pkg::IRQ_W-1:0] irq_clr;

  // ==========================================================================
  // Bus decode.
  // ==========================================================================
  assign req = WB_CYC_I & WB_STB_I & ~ack_reg;
  assign idx = word_index(WB_ADR_I);
  assign hit = in_window(WB_ADR_I);
  assign lane0 = WB_SEL_I[0];
  assign wbyte = WB_DAT_I[nvecc_pkg::REG_W-1:0];
  // A write lands in the cycle its acknowledge is raised, once per request.
  assign wr_take = req & WB_WE_I & lane0 & hit;
  assign rd_take = req & ~WB_WE_I;

  // ==========================================================================
  // Acknowledge and read data.
  // ==========================================================================

  // Every request, mapped or not, is answered one cycle later.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  always_comb begin
    rdata_next = '0;
    if (hit) begin
      unique case (idx)
        nvecc_pkg::IDX_BANK_FLAGS: begin
          rdata_next = to_word(bank_flags_reg);
        end
        nvecc_pkg::IDX_LOAD_STATUS: begin
          // The six upper bits are not stored, so they always read zero.
          rdata_next = '0;
          rdata_next[nvecc_pkg::POS_CONFIG_VALID] = config_valid_reg;
          rdata_next[nvecc_pkg::POS_LOW_VOLTAGE] = low_voltage_reg;
        end
        nvecc_pkg::IDX_IRQ_STATUS: begin
          rdata_next[nvecc_pkg::IRQ_W-1:0] = irq_status_reg;
        end
        nvecc_pkg::IDX_IRQ_MASK: begin
          rdata_next[nvecc_pkg::IRQ_W-1:0] = irq_mask_reg;
        end
        nvecc_pkg::IDX_CFG_ID1: begin
          rdata_next = to_word(cfg_id1_reg);
        end
        nvecc_pkg::IDX_CFG_ID2: begin
          rdata_next = to_word(cfg_id2_reg);
        end
        default: begin
          // The clear register is a strobe and reads as zero.
          rdata_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      rdata_reg <= '0;
    end else if (rd_take) begin
      rdata_reg <= rdata_next;
    end
  end

  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = rdata_reg;

  // ==========================================================================
  // Shared fault clear strobe.
  // ==========================================================================

  // The strobe is not stored: it acts once, in the cycle the write is taken.
  assign clear_pulse = wr_take & (idx == nvecc_pkg::IDX_NVM_CLEAR)
    & wbyte[nvecc_pkg::POS_NVM_FAULT_CLEAR];

  // Other blocks sharing this clear, such as corrected-error flags, use it.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      NVM_CLEAR <= 1'b0;
    end else begin
      NVM_CLEAR <= clear_pulse;
    end
  end

  // ==========================================================================
  // Per-bank uncorrectable flags.
  // ==========================================================================
  always_comb begin
    bank_set = '0;
    if (ECC_EVT.valid) begin
      bank_set[ECC_EVT.bank] = 1'b1;
    end
    // A bank failing in the clear cycle stays flagged.
    bank_flags_next = sticky(bank_flags_reg, bank_set,
      {nvecc_pkg::REG_W{clear_pulse}});
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      bank_flags_reg <= nvecc_pkg::RST_BANK_FLAGS;
    end else begin
      bank_flags_reg <= bank_flags_next;
    end
  end

  // ==========================================================================
  // Configuration identifiers.
  // ==========================================================================

  // Software may also rewrite the identifiers; this does not touch the
  // valid flag, which changes only on a load or on the clear strobe.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      cfg_id1_reg <= nvecc_pkg::RST_CFG_ID;
      cfg_id2_reg <= nvecc_pkg::RST_CFG_ID;
    end else if (LOAD_EVT.valid) begin
      cfg_id1_reg <= LOAD_EVT.id1;
      cfg_id2_reg <= LOAD_EVT.id2;
    end else if (wr_take) begin
      if (idx == nvecc_pkg::IDX_CFG_ID1) begin
        cfg_id1_reg <= wbyte;
      end
      if (idx == nvecc_pkg::IDX_CFG_ID2) begin
        cfg_id2_reg <= wbyte;
      end
    end
  end

  assign load_ids_nonzero = (LOAD_EVT.id1 != '0) | (LOAD_EVT.id2 != '0);

  // ==========================================================================
  // Memory status flags.
  // ==========================================================================
  always_comb begin
    config_valid_next = config_valid_reg;
    if (clear_pulse) begin
      config_valid_next = 1'b0;
    end
    if (LOAD_EVT.valid) begin
      config_valid_next = load_ids_nonzero;
    end
  end

  always_comb begin
    low_voltage_next = low_voltage_reg;
    if (clear_pulse) begin
      low_voltage_next = 1'b0;
    end
    // A supply still low after a clear latches again at once.
    if (vdd_low_reg) begin
      low_voltage_next = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      config_valid_reg <=
        nvecc_pkg::RST_LOAD_STATUS[nvecc_pkg::POS_CONFIG_VALID];
      low_voltage_reg <=
        nvecc_pkg::RST_LOAD_STATUS[nvecc_pkg::POS_LOW_VOLTAGE];
    end else begin
      config_valid_reg <= config_valid_next;
      low_voltage_reg <= low_voltage_next;
    end
  end

  // ==========================================================================
  // Supply monitor input.
  // ==========================================================================

  // The monitor is asynchronous; the filtered level moves only when the
  // second and third stages agree, so one-cycle glitches are dropped.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      vdd_meta_reg <= 1'b0;
      vdd_s2_reg <= 1'b0;
      vdd_s3_reg <= 1'b0;
    end else begin
      vdd_meta_reg <= NVM_VDD_LOW;
      vdd_s2_reg <= vdd_meta_reg;
      vdd_s3_reg <= vdd_s2_reg;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      vdd_low_reg <= 1'b0;
    end else if (vdd_s2_reg == vdd_s3_reg) begin
      vdd_low_reg <= vdd_s3_reg;
    end
  end

  assign vdd_low_rise = vdd_low_reg & ~low_voltage_reg;

  // ==========================================================================
  // Interrupt status and mask.
  // ==========================================================================
  always_comb begin
    irq_set = '0;
    irq_set[nvecc_pkg::POS_IRQ_UNCORR] = ECC_EVT.valid;
    irq_set[nvecc_pkg::POS_IRQ_LOW_VOLTAGE] = vdd_low_rise;
    irq_set[nvecc_pkg::POS_IRQ_LOAD_DONE] = LOAD_EVT.valid;
    irq_clr = '0;
    if (wr_take && idx == nvecc_pkg::IDX_IRQ_STATUS) begin
      irq_clr = wbyte[nvecc_pkg::IRQ_W-1:0];
    end
    // Write-one-to-clear; an event in the same cycle keeps its bit set.
    irq_status_next = (irq_status_reg & ~irq_clr) | irq_set;
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      irq_status_reg <= nvecc_pkg::RST_IRQ_STATUS;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      irq_mask_reg <= nvecc_pkg::RST_IRQ_MASK;
    end else if (wr_take && idx == nvecc_pkg::IDX_IRQ_MASK) begin
      irq_mask_reg <= wbyte[nvecc_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_status_next & irq_mask_reg);
    end
  end

endmodule

//--- verif/nvecc_status_properties.sv
`timescale 1ns/1ps

// ============================================================================
// Bus, clear pulse and reset checks.
// ============================================================================
module nvecc_status_properties (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [nvecc_pkg::ADDR_W-1:0] WB_ADR_I,
  input wire logic [nvecc_pkg::SEL_W-1:0] WB_SEL_I,
  input wire logic [nvecc_pkg::DATA_W-1:0] WB_DAT_I,
  input wire logic [nvecc_pkg::DATA_W-1:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic NVM_CLEAR,
  input wire logic IRQ
);
  localparam logic [31:0] A_CLR = {22'h0, nvecc_pkg::IDX_NVM_CLEAR, 2'h0};
  localparam logic [31:0] A_STS = {22'h0, nvecc_pkg::IDX_LOAD_STATUS, 2'h0};
  logic take;
  logic clr_take;
  logic clr_q;
  logic rd_sts_q;
  assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign clr_take = take && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == A_CLR &&
                    WB_DAT_I[4];

  // The helpers are reset so that no stale take leaks across a reset.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      clr_q <= 1'b0;
      rd_sts_q <= 1'b0;
    end else begin
      clr_q <= clr_take;
      rd_sts_q <= take && !WB_WE_I && WB_ADR_I == A_STS;
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);

  a_ack_answer: assert property (take |=> WB_ACK_O)
    else $error("no ack one cycle after a request");
  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  a_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(WB_STB_I))
    else $error("ack without a strobe");
  a_clear_pulse: assert property (clr_take |=> NVM_CLEAR)
    else $error("clear pulse missing after clear write");
  a_clear_cause: assert property (NVM_CLEAR |-> clr_q)
    else $error("clear pulse without clear write");
  a_reset_quiet: assert property (disable iff (1'b0) !RESETN |=>
    !WB_ACK_O && !NVM_CLEAR && !IRQ && WB_DAT_O == 32'h0)
    else $error("outputs not quiet after reset");
  a_status_upper: assert property (rd_sts_q && WB_ACK_O |->
    WB_DAT_O[7:2] == 6'h0)
    else $error("status upper bits not zero");
  a_data_hold: assert property (!(take && !WB_WE_I) |=> $stable(WB_DAT_O))
    else $error("read data changed without a read");

  c_clear: cover property (clr_take);
  c_valid_read: cover property (rd_sts_q && WB_ACK_O && WB_DAT_O[1]);
  c_irq: cover property ($rose(IRQ));
endmodule

bind nvecc_status nvecc_status_properties chk (
  .CLK(CLK), .RESETN(RESETN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
  .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .NVM_CLEAR(NVM_CLEAR), .IRQ(IRQ)
);

//--- verif/nvecc_status_tb.sv
`timescale 1ns/1ps

// ============================================================================
// Register level bench for the status block.
// ============================================================================
module nvecc_status_tb;
  logic clk, resetn, cyc, stb, we, vdd_low, ack, nvm_clear, irq, clr_seen;
  logic [31:0] adr, dat, rdat, q;
  logic [3:0] sel;
  logic [7:0] exp_flags;
  logic [23:0] tbl [4];
  nvecc_pkg::nvecc_ecc_evt_s ecc;
  nvecc_pkg::nvecc_load_evt_s load;
  int err_total, n_tests;

  always #4 clk = ~clk;

  nvecc_status uut (
    .CLK(clk), .RESETN(resetn), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .ECC_EVT(ecc), .LOAD_EVT(load),
    .NVM_VDD_LOW(vdd_low), .NVM_CLEAR(nvm_clear), .IRQ(irq)
  );

  // ==========================================================================
  // Compare, bus and event tasks.
  // ==========================================================================
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: reg %h, want %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: level %b, want %b", $time, got, exp);
    end
  endtask

  // The wait is open ended; only the watchdog cuts a hung bus short.
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= {22'h0, idx, 2'h0};
    dat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    clr_seen = nvm_clear;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00);
    chk_reg(q, {24'h0, e});
  endtask

  task automatic ecc_pulse(input int b);
    @(posedge clk);
    ecc <= '{valid: 1'b1, bank: b[2:0]};
    @(posedge clk);
    ecc.valid <= 1'b0;
  endtask

  task automatic load_pulse(input logic [7:0] a, input logic [7:0] b);
    @(posedge clk);
    load <= '{valid: 1'b1, id1: a, id2: b};
    @(posedge clk);
    load.valid <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
  endtask

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================================
  // Tests.
  // ==========================================================================
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    {cyc, stb, we, vdd_low} = 4'h0;
    {adr, dat, sel} = '0;
    ecc = '0;
    load = '0;
    err_total = 0;
    n_tests = 0;
    tbl = '{24'h005a02, 24'h010002, 24'h000000, 24'h808002};
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 4; i++)
      rd_chk(nvecc_pkg::IDX_BANK_FLAGS + i[7:0], 8'h00);
    chk_bit(irq, 1'b0);
    $display("test reset done");
    wb(1'b1, nvecc_pkg::IDX_IRQ_MASK, 8'h01);
    exp_flags = 8'h00;
    for (int b = 0; b < 8; b++) begin
      ecc_pulse(b);
      exp_flags[b] = 1'b1;
      rd_chk(nvecc_pkg::IDX_BANK_FLAGS, exp_flags);
    end
    chk_bit(irq, 1'b1);
    wb(1'b1, nvecc_pkg::IDX_IRQ_MASK, 8'h00);
    @(posedge clk);
    chk_bit(irq, 1'b0);
    wb(1'b1, nvecc_pkg::IDX_IRQ_MASK, 8'h01);
    @(posedge clk);
    chk_bit(irq, 1'b1);
    wb(1'b1, nvecc_pkg::IDX_IRQ_STATUS, 8'h01);
    @(posedge clk);
    chk_bit(irq, 1'b0);
    $display("test banks done");
    wb(1'b1, nvecc_pkg::IDX_NVM_CLEAR, 8'hef);
    chk_bit(clr_seen, 1'b0);
    rd_chk(nvecc_pkg::IDX_BANK_FLAGS, 8'hff);
    wb(1'b1, nvecc_pkg::IDX_BANK_FLAGS, 8'h00);
    rd_chk(nvecc_pkg::IDX_BANK_FLAGS, 8'hff);
    wb(1'b1, nvecc_pkg::IDX_NVM_CLEAR, 8'h10);
    chk_bit(clr_seen, 1'b1);
    rd_chk(nvecc_pkg::IDX_BANK_FLAGS, 8'h00);
    $display("test clear done");
    for (int i = 0; i < 4; i++) begin
      load_pulse(tbl[i][23:16], tbl[i][15:8]);
      rd_chk(nvecc_pkg::IDX_LOAD_STATUS, tbl[i][7:0]);
    end
    rd_chk(nvecc_pkg::IDX_CFG_ID1, 8'h80);
    wb(1'b1, nvecc_pkg::IDX_CFG_ID1, 8'h00);
    wb(1'b1, nvecc_pkg::IDX_CFG_ID2, 8'h00);
    rd_chk(nvecc_pkg::IDX_CFG_ID2, 8'h00);
    wb(1'b1, nvecc_pkg::IDX_LOAD_STATUS, 8'hfc);
    rd_chk(nvecc_pkg::IDX_LOAD_STATUS, 8'h02);
    wb(1'b1, nvecc_pkg::IDX_NVM_CLEAR, 8'h10);
    rd_chk(nvecc_pkg::IDX_LOAD_STATUS, 8'h00);
    $display("test config done");
    @(posedge clk);
    vdd_low <= 1'b1;
    repeat (8) @(posedge clk);
    rd_chk(nvecc_pkg::IDX_LOAD_STATUS, 8'h01);
    rd_chk(nvecc_pkg::IDX_IRQ_STATUS, 8'h06);
    wb(1'b1, nvecc_pkg::IDX_NVM_CLEAR, 8'h10);
    rd_chk(nvecc_pkg::IDX_LOAD_STATUS, 8'h01);
    vdd_low <= 1'b0;
    repeat (8) @(posedge clk);
    wb(1'b1, nvecc_pkg::IDX_NVM_CLEAR, 8'h10);
    rd_chk(nvecc_pkg::IDX_LOAD_STATUS, 8'h00);
    $display("test voltage done");
    rd_chk(8'h7f, 8'h00);
    wb(1'b1, 8'h7f, 8'hff);
    rd_chk(8'h7f, 8'h00);
    ecc_pulse(3);
    rd_chk(nvecc_pkg::IDX_BANK_FLAGS, 8'h08);
    do_reset();
    rd_chk(nvecc_pkg::IDX_BANK_FLAGS, 8'h00);
    $display("test unmapped and reset done");
    summarize();
  end

  // The tests need about two hundred cycles; twenty-five times that means a hang.
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize();
  end
endmodule
